// ---- rtcpt_defs.svh ----
// Register map, field positions, reset values and sync counts of the RTC and tick timer block
// What this block does
// - Counter runs in idle sleep; in standby only when run_in_standby (bit 7) is set.
// - Periodic tick timer keeps running in every sleep mode.
// - Counter and tick logic advance on the slow timebase clock, crossed into the bus clock.
// - Status bits 3..0 show compare, period, count and control synchronisation busy.
// - Tick status bit 0 is busy while a tick control write is synchronised.
// - Prescaler change takes effect two slow clock cycles after the write; control busy meanwhile.
// - Prescaler field bits 6:3 divides the slow clock by two to its value.
// - Control bit 0 counter_enable starts and stops the counter; resets to 0.
// - Interrupt enable bit 1 enables the compare_match interrupt.
// - Interrupt enable bit 0 enables the wrap_event interrupt.
// - Flag bit 1 sets on compare match; writing 1 clears it.
// - Flag bit 0 sets when the counter wraps at period; writing 1 clears it.
// - One shared byte latch, software readable and writable, serves all 16-bit registers.
// - Tick interval 0 disables ticks, n in 1..14 gives 2^(n+1) slow cycles, 15 reserved.
// - periodic_tick flag sets on each tick; writing 1 clears it.
// - Two-bit timebase source select picks the slow clock source.
// - Count and period writes take effect two slow cycles later; software waits for busy clear.
`ifndef RTCPT_DEFS_SVH
`define RTCPT_DEFS_SVH

// Register indices; the byte address is four times the index
`define RTCPT_IDX_CTRL      5'h00
`define RTCPT_IDX_STATUS    5'h01
`define RTCPT_IDX_INT_EN    5'h02
`define RTCPT_IDX_FLAGS     5'h03
`define RTCPT_IDX_TEMP      5'h04
`define RTCPT_IDX_HALT      5'h05
`define RTCPT_IDX_TIMEBASE_SOURCE    5'h07
`define RTCPT_IDX_CNT_LO    5'h08
`define RTCPT_IDX_CNT_HI    5'h09
`define RTCPT_IDX_PER_LO    5'h0A
`define RTCPT_IDX_PER_HI    5'h0B
`define RTCPT_IDX_CMP_LO    5'h0C
`define RTCPT_IDX_CMP_HI    5'h0D
`define RTCPT_IDX_TICK_CTRL 5'h10
`define RTCPT_IDX_TICK_STAT 5'h11
`define RTCPT_IDX_TICK_EN   5'h12
`define RTCPT_IDX_TICK_FLAG 5'h13
`define RTCPT_IDX_TICK_HALT 5'h15
`define RTCPT_IDX_EVT_STAT  5'h18
`define RTCPT_IDX_EVT_MASK  5'h19

// Writable bits of each register
`define RTCPT_CTRL_MASK     8'hF9
`define RTCPT_TICK_MASK     8'h79
`define RTCPT_INT_MASK      8'h03
`define RTCPT_BIT0_MASK     8'h01
`define RTCPT_TIMEBASE_SOURCE_MASK   8'h03

// Field positions
`define RTCPT_RUN_STDBY_BIT 7
`define RTCPT_ENABLE_BIT    0
`define RTCPT_DIV_MSB       6
`define RTCPT_DIV_LSB       3

// Busy vector positions
`define RTCPT_B_CTRL        0
`define RTCPT_B_CNT         1
`define RTCPT_B_PER         2
`define RTCPT_B_CMP         3
`define RTCPT_B_TICK        4

// Reset values and timing
`define RTCPT_PER_RESET     16'hFFFF
`define RTCPT_SYNC_EDGES    2

`endif

// ---- rtcpt_pkg.sv ----
// Types shared by the RTC and tick timer block
package rtcpt_pkg;

  typedef enum logic [1:0] {
    RTCPT_ACTIVE  = 2'b00,
    RTCPT_IDLE    = 2'b01,
    RTCPT_STANDBY = 2'b11
  } rtcpt_sleep_t;

  typedef struct packed {
    logic [1:0]      slow_sync;
    logic            slow_prev;
    logic [7:0]      ctrl_w;
    logic [7:0]      ctrl_s;
    logic [7:0]      int_en;
    logic [7:0]      flags;
    logic [7:0]      temp;
    logic [7:0]      halt_ctl;
    logic [7:0]      timebase_source;
    logic [15:0]     cnt;
    logic [15:0]     cnt_w;
    logic [15:0]     per_w;
    logic [15:0]     per_s;
    logic [15:0]     cmp_w;
    logic [15:0]     cmp_s;
    logic [7:0]      tick_w;
    logic [7:0]      tick_s;
    logic [7:0]      tick_en;
    logic [7:0]      tick_flag;
    logic [7:0]      tick_halt;
    logic [4:0]      busy;
    logic [4:0][1:0] sync_cnt;
    logic [14:0]     presc;
    logic [2:0]      evt_stat;
    logic [2:0]      evt_mask;
    logic            ack;
    logic [31:0]     dat;
    logic            irq;
    logic            rtc_irq;
    logic            tick_irq;
    logic            wrap_evt;
    logic            cmp_evt;
    logic            tick_evt;
  } rtcpt_state_t;

endpackage

// ---- rtcpt_top.sv ----
// RTC counter and periodic tick timer with a classic Wishbone register slave
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "rtcpt_defs.svh"

module rtcpt_top import rtcpt_pkg::*; (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [6:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic       [31:0] dat_o,
  output logic              ack_o,
  input  wire logic         slow_clk_i,
  input  wire rtcpt_sleep_t sleep_mode_i,
  input  wire logic         halt_i,
  output logic       [1:0]  timebase_sel_o,
  output logic              irq_o,
  output logic              rtc_irq_o,
  output logic              tick_irq_o,
  output logic              wrap_evt_o,
  output logic              cmp_evt_o,
  output logic              tick_evt_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // True when the low k prescaler bits are all ones; k = 0 is always true
  function automatic logic low_ones(input logic [14:0] v, input logic [4:0] k);
    logic [14:0] m;
    m = (15'h0001 << k) - 15'h0001;
    return (v & m) == m;
  endfunction

  rtcpt_state_t s;
  rtcpt_state_t n;

  logic       req;
  logic       wr;
  logic [4:0] idx;
  logic [7:0] wd;
  logic       slow_edge;
  logic       rtc_run;
  logic       rtc_step;
  logic       tick_run;
  logic [3:0] tick_sel;
  logic [15:0] cnt_next;
  logic [1:0] rtc_set;
  logic [1:0] rtc_clr;
  logic       tick_set;
  logic       tick_clr;
  logic [2:0] stat_clr;

  assign req       = cyc_i & stb_i & ~s.ack;
  assign wr        = req & we_i & sel_i[0];
  assign idx       = adr_i[6:2];
  assign wd        = dat_i[7:0];
  // Only the second synchroniser stage feeds the edge detector
  assign slow_edge = s.slow_sync[1] & ~s.slow_prev;
  assign tick_sel  = s.tick_s[`RTCPT_DIV_MSB:`RTCPT_DIV_LSB];

  // Counter gating by sleep mode and debug halt
  assign rtc_run = s.ctrl_s[`RTCPT_ENABLE_BIT]
                 & (sleep_mode_i != RTCPT_STANDBY | s.ctrl_s[`RTCPT_RUN_STDBY_BIT])
                 & (~halt_i | s.halt_ctl[0]);
  assign rtc_step = slow_edge & rtc_run
                  & low_ones(s.presc, {1'b0, s.ctrl_s[`RTCPT_DIV_MSB:`RTCPT_DIV_LSB]});
  // Tick timer ignores sleep entirely
  assign tick_run = s.tick_s[`RTCPT_ENABLE_BIT] & (~halt_i | s.tick_halt[0]);
  assign cnt_next = (s.cnt == s.per_s) ? 16'h0000 : s.cnt + 16'h0001;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n          = s;
    n.ack      = req;
    n.wrap_evt = 1'b0;
    n.cmp_evt  = 1'b0;
    n.tick_evt = 1'b0;
    n.slow_sync = {s.slow_sync[0], slow_clk_i};
    n.slow_prev = s.slow_sync[1];
    rtc_set  = 2'b00;
    rtc_clr  = 2'b00;
    tick_set = 1'b0;
    tick_clr = 1'b0;
    stat_clr = 3'b000;

    if (slow_edge) begin
      // Shared prescaler stops and restarts from zero when both users are off
      if (s.ctrl_s[`RTCPT_ENABLE_BIT] | s.tick_s[`RTCPT_ENABLE_BIT]) begin
        n.presc = s.presc + 15'h0001;
      end else begin
        n.presc = 15'h0000;
      end
      if (rtc_step) begin
        n.cnt = cnt_next;
        if (s.cnt == s.per_s) begin
          rtc_set[0] = 1'b1;
          n.wrap_evt = 1'b1;
        end
        if (cnt_next == s.cmp_s) begin
          rtc_set[1] = 1'b1;
          n.cmp_evt  = 1'b1;
        end
      end
      // Codes 0 and 15 never tick
      if (tick_run && tick_sel != 4'h0 && tick_sel != 4'hF
          && low_ones(s.presc, 5'(tick_sel) + 5'h01)) begin
        tick_set   = 1'b1;
        n.tick_evt = 1'b1;
      end
      // A pending write lands on the second slow edge and overrides the count step
      for (int i = 0; i < 5; i++) begin
        if (s.busy[i]) begin
          if (s.sync_cnt[i] == 2'(`RTCPT_SYNC_EDGES - 1)) begin
            n.busy[i] = 1'b0;
            case (i)
              `RTCPT_B_CTRL: n.ctrl_s = s.ctrl_w;
              `RTCPT_B_CNT:  n.cnt    = s.cnt_w;
              `RTCPT_B_PER:  n.per_s  = s.per_w;
              `RTCPT_B_CMP:  n.cmp_s  = s.cmp_w;
              default:       n.tick_s = s.tick_w;
            endcase
          end else begin
            n.sync_cnt[i] = s.sync_cnt[i] + 2'h1;
          end
        end
      end
    end

    if (req) begin
      n.dat = 32'h0000_0000;
      if (we_i) begin
        if (sel_i[0]) begin
          case (idx)
            `RTCPT_IDX_CTRL: begin
              n.ctrl_w = wd & `RTCPT_CTRL_MASK;
              n.busy[`RTCPT_B_CTRL]     = 1'b1;
              n.sync_cnt[`RTCPT_B_CTRL] = 2'h0;
            end
            `RTCPT_IDX_INT_EN:    n.int_en = wd & `RTCPT_INT_MASK;
            `RTCPT_IDX_FLAGS:     rtc_clr = wd[1:0];
            `RTCPT_IDX_TEMP:      n.temp = wd;
            `RTCPT_IDX_HALT:      n.halt_ctl = wd & `RTCPT_BIT0_MASK;
            `RTCPT_IDX_TIMEBASE_SOURCE:    n.timebase_source = wd & `RTCPT_TIMEBASE_SOURCE_MASK;
            `RTCPT_IDX_CNT_LO,
            `RTCPT_IDX_PER_LO,
            `RTCPT_IDX_CMP_LO:    n.temp = wd;
            `RTCPT_IDX_CNT_HI: begin
              n.cnt_w = {wd, s.temp};
              n.busy[`RTCPT_B_CNT]     = 1'b1;
              n.sync_cnt[`RTCPT_B_CNT] = 2'h0;
            end
            `RTCPT_IDX_PER_HI: begin
              n.per_w = {wd, s.temp};
              n.busy[`RTCPT_B_PER]     = 1'b1;
              n.sync_cnt[`RTCPT_B_PER] = 2'h0;
            end
            `RTCPT_IDX_CMP_HI: begin
              n.cmp_w = {wd, s.temp};
              n.busy[`RTCPT_B_CMP]     = 1'b1;
              n.sync_cnt[`RTCPT_B_CMP] = 2'h0;
            end
            `RTCPT_IDX_TICK_CTRL: begin
              n.tick_w = wd & `RTCPT_TICK_MASK;
              n.busy[`RTCPT_B_TICK]     = 1'b1;
              n.sync_cnt[`RTCPT_B_TICK] = 2'h0;
            end
            `RTCPT_IDX_TICK_EN:   n.tick_en = wd & `RTCPT_BIT0_MASK;
            `RTCPT_IDX_TICK_FLAG: tick_clr = wd[0];
            `RTCPT_IDX_TICK_HALT: n.tick_halt = wd & `RTCPT_BIT0_MASK;
            `RTCPT_IDX_EVT_MASK:  n.evt_mask = wd[2:0];
            default: ;
          endcase
        end
      end else begin
        case (idx)
          `RTCPT_IDX_CTRL:      n.dat[7:0] = s.ctrl_w;
          `RTCPT_IDX_STATUS:    n.dat[3:0] = s.busy[3:0];
          `RTCPT_IDX_INT_EN:    n.dat[7:0] = s.int_en;
          `RTCPT_IDX_FLAGS:     n.dat[7:0] = s.flags;
          `RTCPT_IDX_TEMP:      n.dat[7:0] = s.temp;
          `RTCPT_IDX_HALT:      n.dat[7:0] = s.halt_ctl;
          `RTCPT_IDX_TIMEBASE_SOURCE:    n.dat[7:0] = s.timebase_source;
          `RTCPT_IDX_CNT_LO: begin
            n.dat[7:0] = s.cnt[7:0];
            n.temp     = s.cnt[15:8];
          end
          `RTCPT_IDX_PER_LO: begin
            n.dat[7:0] = s.per_w[7:0];
            n.temp     = s.per_w[15:8];
          end
          `RTCPT_IDX_CMP_LO: begin
            n.dat[7:0] = s.cmp_w[7:0];
            n.temp     = s.cmp_w[15:8];
          end
          `RTCPT_IDX_CNT_HI,
          `RTCPT_IDX_PER_HI,
          `RTCPT_IDX_CMP_HI:    n.dat[7:0] = s.temp;
          `RTCPT_IDX_TICK_CTRL: n.dat[7:0] = s.tick_w;
          `RTCPT_IDX_TICK_STAT: n.dat[0]   = s.busy[`RTCPT_B_TICK];
          `RTCPT_IDX_TICK_EN:   n.dat[7:0] = s.tick_en;
          `RTCPT_IDX_TICK_FLAG: n.dat[7:0] = s.tick_flag;
          `RTCPT_IDX_TICK_HALT: n.dat[7:0] = s.tick_halt;
          `RTCPT_IDX_EVT_STAT: begin
            n.dat[2:0] = s.evt_stat;
            stat_clr   = 3'b111;
          end
          `RTCPT_IDX_EVT_MASK:  n.dat[2:0] = s.evt_mask;
          default: ;
        endcase
      end
    end

    // A setting event wins over a clear in the same cycle
    n.flags[1:0]   = (s.flags[1:0] & ~rtc_clr) | rtc_set;
    n.tick_flag[0] = (s.tick_flag[0] & ~tick_clr) | tick_set;
    n.evt_stat     = (s.evt_stat & ~stat_clr) | {tick_set, rtc_set[1], rtc_set[0]};
    n.irq          = |(n.evt_stat & n.evt_mask);
    // Interrupt lines are registered so every output comes straight from a flop
    n.rtc_irq      = |(n.flags[1:0] & n.int_en[1:0]);
    n.tick_irq     = n.tick_flag[0] & n.tick_en[0];
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s       <= '0;
      s.per_w <= `RTCPT_PER_RESET;
      s.per_s <= `RTCPT_PER_RESET;
    end else begin
      s <= n;
    end
  end

  assign dat_o          = s.dat;
  assign ack_o          = s.ack;
  assign timebase_sel_o = s.timebase_source[1:0];
  assign irq_o          = s.irq;
  assign rtc_irq_o      = s.rtc_irq;
  assign tick_irq_o     = s.tick_irq;
  assign wrap_evt_o     = s.wrap_evt;
  assign cmp_evt_o      = s.cmp_evt;
  assign tick_evt_o     = s.tick_evt;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctrl_write;
    wr && idx == `RTCPT_IDX_CTRL;
  endsequence

  sequence s_ctrl_busy_set;
    s.busy[`RTCPT_B_CTRL] && s.sync_cnt[`RTCPT_B_CTRL] == 2'h0;
  endsequence

  sequence s_tick_ctrl_write;
    wr && idx == `RTCPT_IDX_TICK_CTRL;
  endsequence

  property p_ack_single;
    s.ack |=> !s.ack;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held longer than one cycle");

  property p_ctrl_busy;
    s_ctrl_write |=> s_ctrl_busy_set;
  endproperty
  a_ctrl_busy: assert property (p_ctrl_busy) else $error("control write did not raise busy");

  property p_busy_falls_on_edge;
    $fell(s.busy[`RTCPT_B_CTRL]) |-> $past(slow_edge) && $past(s.sync_cnt[`RTCPT_B_CTRL]) == 2'h1;
  endproperty
  a_busy_falls_on_edge: assert property (p_busy_falls_on_edge) else $error("control busy cleared early");

  property p_disabled_holds;
    !s.ctrl_s[`RTCPT_ENABLE_BIT] && !s.busy[`RTCPT_B_CNT] |=> $stable(s.cnt);
  endproperty
  a_disabled_holds: assert property (p_disabled_holds) else $error("counter moved while disabled");

  property p_standby_stop;
    sleep_mode_i == RTCPT_STANDBY && !s.ctrl_s[`RTCPT_RUN_STDBY_BIT] && !s.busy[`RTCPT_B_CNT]
      |=> $stable(s.cnt);
  endproperty
  a_standby_stop: assert property (p_standby_stop) else $error("counter ran in standby");

  property p_wrap;
    rtc_step && s.cnt == s.per_s && !s.busy[`RTCPT_B_CNT] |=> s.cnt == 16'h0000 && s.flags[0] && s.wrap_evt;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap at period missing");

  property p_cmp_clear;
    wr && idx == `RTCPT_IDX_FLAGS && wd[1] && !rtc_set[1] |=> !s.flags[1];
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("compare flag not cleared");

  property p_tick_off;
    tick_sel == 4'h0 |=> !s.tick_evt;
  endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick issued with interval zero");

  property p_latch_high;
    req && !we_i && idx == `RTCPT_IDX_CNT_LO |=> s.temp == $past(s.cnt[15:8]) ##1 !s.ack;
  endproperty
  a_latch_high: assert property (p_latch_high) else $error("high byte not latched");

  property p_tick_busy;
    s_tick_ctrl_write |=> s.busy[`RTCPT_B_TICK];
  endproperty
  a_tick_busy: assert property (p_tick_busy) else $error("tick control write did not raise busy");

  property p_tick_reserved;
    tick_sel == 4'hF |=> !s.tick_evt;
  endproperty
  a_tick_reserved: assert property (p_tick_reserved) else $error("tick issued with reserved interval");

  property p_wrap_flag_wins;
    rtc_set[0] |=> s.flags[0];
  endproperty
  a_wrap_flag_wins: assert property (p_wrap_flag_wins) else $error("wrap flag lost to a clear");

  property p_tick_flag;
    tick_set |=> s.tick_flag[0] && s.tick_evt;
  endproperty
  a_tick_flag: assert property (p_tick_flag) else $error("tick did not set its flag");

  property p_cnt_apply;
    slow_edge && s.busy[`RTCPT_B_CNT] && s.sync_cnt[`RTCPT_B_CNT] == 2'h1 |=> s.cnt == $past(s.cnt_w);
  endproperty
  a_cnt_apply: assert property (p_cnt_apply) else $error("count write not applied on second slow edge");

  property p_irq_follow;
    req && !we_i && idx == `RTCPT_IDX_EVT_STAT && !tick_set && rtc_set == 2'b00 |=> !s.irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("event status read left interrupt high");

endmodule // rtcpt_top

// ---- rtcpt_tb_top.sv ----
// Self-checking testbench for the RTC counter and periodic tick block
`timescale 1ns/1ps
`include "rtcpt_defs.svh"

module rtcpt_tb_top import rtcpt_pkg::*; ();

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic         clk_i        = 1'b0;
  logic         rst_i        = 1'b1;
  logic         cyc_i        = 1'b0;
  logic         stb_i        = 1'b0;
  logic         we_i         = 1'b0;
  logic [6:0]   adr_i        = 7'h00;
  logic [3:0]   sel_i        = 4'h0;
  logic [31:0]  dat_i        = 32'h0;
  logic         slow_clk_i   = 1'b0;
  logic         halt_i       = 1'b0;
  rtcpt_sleep_t sleep_mode_i = RTCPT_ACTIVE;
  logic [31:0]  dat_o;
  logic         ack_o;
  logic [1:0]   timebase_sel_o;
  logic         irq_o;
  logic         rtc_irq_o;
  logic         tick_irq_o;
  logic         wrap_evt_o;
  logic         cmp_evt_o;
  logic         tick_evt_o;
  int           n_mismatch   = 0;
  int           compares     = 0;
  int           cycles       = 0;
  int           n_tick       = 0;
  int           n_wrap       = 0;
  int           n_cmp        = 0;
  int           t0;
  logic [7:0]   rd;
  logic [7:0]   c0;
  logic [7:0]   c1;
  logic [4:0]   t_idx [7] = '{`RTCPT_IDX_TEMP, `RTCPT_IDX_INT_EN, `RTCPT_IDX_HALT, `RTCPT_IDX_TICK_EN,
                              `RTCPT_IDX_TICK_HALT, 5'h06, `RTCPT_IDX_STATUS};
  logic [7:0]   t_exp [7] = '{8'hFF, 8'h03, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};

  rtcpt_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .slow_clk_i(slow_clk_i),
    .sleep_mode_i(sleep_mode_i), .halt_i(halt_i), .timebase_sel_o(timebase_sel_o), .irq_o(irq_o),
    .rtc_irq_o(rtc_irq_o), .tick_irq_o(tick_irq_o), .wrap_evt_o(wrap_evt_o), .cmp_evt_o(cmp_evt_o),
    .tick_evt_o(tick_evt_o));

  // ----------------------------------------------------------------
  // Clocks, timeout and event counting
  // ----------------------------------------------------------------
  initial forever #5 clk_i = ~clk_i;

  // Slow clock of 10 bus cycles, driven on the bus clock edge; the design still crosses it as a pin
  always @(posedge clk_i) begin
    cycles++;
    if (cycles % 5 == 0) slow_clk_i <= ~slow_clk_i;
    if (tick_evt_o === 1'b1) n_tick++;
    if (wrap_evt_o === 1'b1) n_wrap++;
    if (cmp_evt_o === 1'b1) n_cmp++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi, input string what);
    check({15'h0, v >= lo && v <= hi}, 16'h0001, what);
  endtask

  // One classic Wishbone cycle; request held until ack is sampled high, only the bench timeout ends a wait
  task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] wd, input logic [3:0] sel,
                     output logic [7:0] rdv);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= sel;
    dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1);
    rdv = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    check(16'(k), 16'h0002, "ack one cycle after request");
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    bus(1'b1, idx, d, 4'hF, dummy);
  endtask

  task automatic rd8(input logic [4:0] idx, input logic [7:0] exp, input string what);
    bus(1'b0, idx, 8'h00, 4'hF, rd);
    check({8'h0, rd}, {8'h0, exp}, what);
  endtask

  // Polls a busy bit, as software must before the next synchronised write
  task automatic wait_idle(input logic [4:0] idx, input int b);
    int k;
    k = 0;
    do begin
      bus(1'b0, idx, 8'h00, 4'hF, rd);
      k++;
    end while (rd[b] !== 1'b0 && k < 100);
    check({15'h0, rd[b]}, 16'h0, "busy never clears");
  endtask

  task automatic slow(input int n);
    repeat (n) @(posedge slow_clk_i);
    repeat (4) @(posedge clk_i);
  endtask

  task automatic cnt_lo(output logic [7:0] v);
    bus(1'b0, `RTCPT_IDX_CNT_LO, 8'h00, 4'hF, v);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd8(`RTCPT_IDX_CTRL, 8'h00, "ctrl reset");
    rd8(`RTCPT_IDX_STATUS, 8'h00, "status reset");
    rd8(`RTCPT_IDX_TICK_STAT, 8'h00, "tick status reset");
    rd8(`RTCPT_IDX_PER_LO, 8'hFF, "period low reset");
    rd8(`RTCPT_IDX_TEMP, 8'hFF, "latch holds period high");
    rd8(`RTCPT_IDX_PER_HI, 8'hFF, "period high reset");
    for (int i = 0; i < 7; i++) begin
      wr(t_idx[i], 8'hFF);
      rd8(t_idx[i], t_exp[i], "register access");
    end
    wr(`RTCPT_IDX_TEMP, 8'h5A);
    bus(1'b1, `RTCPT_IDX_TEMP, 8'h33, 4'hE, rd);
    rd8(`RTCPT_IDX_TEMP, 8'h5A, "latch read write");
    wr(`RTCPT_IDX_INT_EN, 8'h00);
    wr(`RTCPT_IDX_HALT, 8'h00);
    wr(`RTCPT_IDX_TICK_EN, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(`RTCPT_IDX_TIMEBASE_SOURCE, 8'(s));
      repeat (2) @(posedge clk_i);
      check({14'h0, timebase_sel_o}, 16'(s), "timebase select");
    end
    // Compare 5, period 7, count 0: both events in one pass
    wr(`RTCPT_IDX_CMP_LO, 8'h05);
    wr(`RTCPT_IDX_CMP_HI, 8'h00);
    rd8(`RTCPT_IDX_STATUS, 8'h08, "compare busy");
    wait_idle(`RTCPT_IDX_STATUS, 3);
    wr(`RTCPT_IDX_PER_LO, 8'h07);
    wr(`RTCPT_IDX_PER_HI, 8'h00);
    rd8(`RTCPT_IDX_STATUS, 8'h04, "period busy");
    wait_idle(`RTCPT_IDX_STATUS, 2);
    rd8(`RTCPT_IDX_PER_LO, 8'h07, "period readback");
    wr(`RTCPT_IDX_CTRL, 8'h01);
    rd8(`RTCPT_IDX_STATUS, 8'h01, "control busy");
    wait_idle(`RTCPT_IDX_STATUS, 0);
    slow(12);
    wr(`RTCPT_IDX_CTRL, 8'h00);
    wait_idle(`RTCPT_IDX_STATUS, 0);
    check({15'h0, rtc_irq_o}, 16'h0, "irq while disabled");
    check({15'h0, irq_o}, 16'h0, "event irq masked");
    rd8(`RTCPT_IDX_FLAGS, 8'h03, "flags after wrap");
    rng(n_wrap, 1, 2, "wrap pulses");
    rng(n_cmp, 1, 2, "compare pulses");
    wr(`RTCPT_IDX_EVT_MASK, 8'h07);
    repeat (2) @(posedge clk_i);
    check({15'h0, irq_o}, 16'h1, "event irq unmasked");
    rd8(`RTCPT_IDX_EVT_STAT, 8'h03, "event status");
    rd8(`RTCPT_IDX_EVT_STAT, 8'h00, "event status read clears");
    check({15'h0, irq_o}, 16'h0, "event irq cleared");
    wr(`RTCPT_IDX_INT_EN, 8'h02);
    @(posedge clk_i);
    check({15'h0, rtc_irq_o}, 16'h1, "compare irq");
    wr(`RTCPT_IDX_FLAGS, 8'h02);
    rd8(`RTCPT_IDX_FLAGS, 8'h01, "compare flag clear");
    check({15'h0, rtc_irq_o}, 16'h0, "compare irq drops");
    wr(`RTCPT_IDX_INT_EN, 8'h01);
    @(posedge clk_i);
    check({15'h0, rtc_irq_o}, 16'h1, "wrap irq");
    wr(`RTCPT_IDX_FLAGS, 8'h01);
    rd8(`RTCPT_IDX_FLAGS, 8'h00, "wrap flag clear");
    // Count write through the latch, then live readback
    wr(`RTCPT_IDX_CNT_LO, 8'h34);
    wr(`RTCPT_IDX_CNT_HI, 8'h12);
    rd8(`RTCPT_IDX_STATUS, 8'h02, "count busy");
    wait_idle(`RTCPT_IDX_STATUS, 1);
    rd8(`RTCPT_IDX_CNT_LO, 8'h34, "count low");
    rd8(`RTCPT_IDX_CNT_HI, 8'h12, "count high");
    // Divide by 4 over 40 slow cycles, full period
    wr(`RTCPT_IDX_CNT_LO, 8'h00);
    wr(`RTCPT_IDX_CNT_HI, 8'h00);
    wr(`RTCPT_IDX_PER_LO, 8'hFF);
    wr(`RTCPT_IDX_PER_HI, 8'hFF);
    wait_idle(`RTCPT_IDX_STATUS, 2);
    wr(`RTCPT_IDX_CTRL, 8'h11);
    rd8(`RTCPT_IDX_CTRL, 8'h11, "ctrl readback");
    wait_idle(`RTCPT_IDX_STATUS, 0);
    slow(40);
    cnt_lo(c0);
    rng(int'(c0), 9, 11, "prescaled count");
    wr(`RTCPT_IDX_CTRL, 8'h01);
    wait_idle(`RTCPT_IDX_STATUS, 0);
    // Sleep behaviour of the counter
    sleep_mode_i <= RTCPT_STANDBY;
    cnt_lo(c0);
    slow(8);
    cnt_lo(c1);
    check({8'h0, c1}, {8'h0, c0}, "standby stops counter");
    sleep_mode_i <= RTCPT_IDLE;
    cnt_lo(c0);
    slow(8);
    cnt_lo(c1);
    rng(int'(8'(c1 - c0)), 7, 9, "idle counts");
    wr(`RTCPT_IDX_CTRL, 8'h81);
    wait_idle(`RTCPT_IDX_STATUS, 0);
    sleep_mode_i <= RTCPT_STANDBY;
    cnt_lo(c0);
    slow(8);
    cnt_lo(c1);
    rng(int'(8'(c1 - c0)), 7, 9, "standby run counts");
    wr(`RTCPT_IDX_CTRL, 8'h00);
    wait_idle(`RTCPT_IDX_STATUS, 0);
    // Tick timer in standby with counter off
    wr(`RTCPT_IDX_TICK_EN, 8'h01);
    wr(`RTCPT_IDX_TICK_CTRL, 8'h01);
    rd8(`RTCPT_IDX_TICK_STAT, 8'h01, "tick busy");
    wait_idle(`RTCPT_IDX_TICK_STAT, 0);
    t0 = n_tick;
    slow(20);
    check(16'(n_tick - t0), 16'h0, "interval zero ticks");
    wr(`RTCPT_IDX_TICK_CTRL, 8'h09);
    wait_idle(`RTCPT_IDX_TICK_STAT, 0);
    t0 = n_tick;
    slow(40);
    rng(n_tick - t0, 9, 11, "ticks every 4 cycles");
    rd8(`RTCPT_IDX_TICK_FLAG, 8'h01, "tick flag");
    check({15'h0, tick_irq_o}, 16'h1, "tick irq");
    wr(`RTCPT_IDX_TICK_CTRL, 8'h79);
    wait_idle(`RTCPT_IDX_TICK_STAT, 0);
    t0 = n_tick;
    slow(20);
    check(16'(n_tick - t0), 16'h0, "reserved interval ticks");
    wr(`RTCPT_IDX_TICK_CTRL, 8'h00);
    wait_idle(`RTCPT_IDX_TICK_STAT, 0);
    wr(`RTCPT_IDX_TICK_FLAG, 8'h01);
    rd8(`RTCPT_IDX_TICK_FLAG, 8'h00, "tick flag clear");
    check({15'h0, tick_irq_o}, 16'h0, "tick irq drops");
    sleep_mode_i <= RTCPT_ACTIVE;
    tally_and_finish();
  end

endmodule // rtcpt_tb_top
